/* include/alu_datapath_regs.svh */
// Constants for the add and logic datapath: widths, flag positions, resets.
// Assumes inclusion by the package by bare name; the design files get its macros through the package.
`ifndef ALU_DATAPATH_REGS_SVH
`define ALU_DATAPATH_REGS_SVH

`define DATA_WIDTH 8
`define WORK_RESET 8'h00
`define FLAGS_RESET 5'h00
// Flag positions inside the status vector
`define FLAG_CARRY 0
`define FLAG_HALF 1
`define FLAG_ZERO 2
`define FLAG_WRAP 3
`define FLAG_SIGN 4
`define FLAG_SPARE 5

`endif

/* include/alu_datapath_pkg.sv */
// Types shared by the datapath top and its arithmetic leaf.
// Assumes alu_datapath_regs.svh is on the include path.
`include "alu_datapath_regs.svh"
package alu_datapath_pkg;

	// *****************************
	// Operation codes from the decoder
	// *****************************
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_ADD_MEM = 3'b001,
		OP_ADD_IMM = 3'b010,
		OP_ADD_INTO_MEM = 3'b011,
		OP_AND_MEM = 3'b100,
		OP_AND_IMM = 3'b101,
		OP_AND_INTO_MEM = 3'b110
	} alu_op_t;

	// Request from the decoder
	typedef struct packed {
		logic valid;
		alu_op_t op;
		logic [`DATA_WIDTH-1:0] mem_data;
		logic [`DATA_WIDTH-1:0] imm_data;
	} alu_req_t;

	// Status flags
	typedef struct packed {
		logic sign;
		logic wrap;
		logic zero;
		logic half;
		logic carry;
	} alu_flags_t;

	// Adder result
	typedef struct packed {
		logic [`DATA_WIDTH-1:0] sum;
		alu_flags_t flags;
	} add_result_t;

	// Memory write-back
	typedef struct packed {
		logic write;
		logic [`DATA_WIDTH-1:0] data;
	} mem_write_t;

	// Whole state of the top
	typedef struct packed {
		logic [`DATA_WIDTH-1:0] working_register;
		alu_flags_t flags;
		mem_write_t mem_wr;
		logic done;
	} datapath_state_t;

endpackage

/* design/byte_adder.sv */
// Combinational byte adder producing the sum and all five add flags.
// Assumes the package is compiled first.
module byte_adder
	import alu_datapath_pkg::*;
#(
	parameter int WIDTH = `DATA_WIDTH
) (
	input wire logic [WIDTH-1:0] a_in, // Working register
	input wire logic [WIDTH-1:0] b_in, // Memory byte or constant
	output add_result_t result_out // Sum and flags
);

	// *****************************
	// Addition
	// *****************************
	logic [WIDTH:0] full;
	logic [4:0] low;

	// Half carry comes from the low nibble alone
	always_comb begin
		full = {1'b0, a_in} + {1'b0, b_in};
		low = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]};
		result_out.sum = full[WIDTH-1:0];
		result_out.flags.carry = full[WIDTH];
		result_out.flags.half = low[4];
		result_out.flags.zero = (full[WIDTH-1:0] == '0);
		// Signed wrap: like-signed operands giving an unlike sign
		result_out.flags.wrap = (a_in[WIDTH-1] == b_in[WIDTH-1])
			&& (full[WIDTH-1] != a_in[WIDTH-1]);
		// True sign of the result, corrected for wrap
		result_out.flags.sign = full[WIDTH-1] ^ result_out.flags.wrap;
	end

endmodule

/* design/add_and_logic_datapath.sv */
// Add and logical AND datapath of the core: working register, flags, write-back.
// Assumes the decoder presents one request per cycle with the memory byte read.
//
// What this block does
// - add-into-memory writes sum to memory only
// - add-into-memory updates all five flags
// - AND memory places result in working register
// - AND immediate places result in working register
// - AND memory/immediate change only zero flag
// - AND-into-memory computes memory AND working register
// - add to working register updates five flags
module add_and_logic_datapath
	import alu_datapath_pkg::*;
#(
	parameter int WIDTH = `DATA_WIDTH
) (
	input wire logic CLOCK_IN, // Core clock
	input wire logic RESET_N_IN, // Asynchronous reset, active low
	input alu_req_t REQ_IN, // Operation and operands
	output logic [WIDTH-1:0] WORKING_REGISTER_OUT, // Working register
	output alu_flags_t FLAGS_OUT, // Status flags
	output mem_write_t MEM_WRITE_OUT, // Write-back to addressed byte
	output logic DONE_OUT // One-cycle completion pulse
);

	// *****************************
	// State
	// *****************************
	datapath_state_t state;
	datapath_state_t next_state;
	add_result_t add_mem;
	add_result_t add_imm;

	// Zero test shared by every AND form
	function automatic logic is_zero(input logic [WIDTH-1:0] v);
		return (v == '0);
	endfunction

	// Two adders so memory and immediate forms need no operand mux
	byte_adder #(
		.WIDTH(WIDTH)
	) mem_adder (
		.a_in(state.working_register),
		.b_in(REQ_IN.mem_data),
		.result_out(add_mem)
	);

	byte_adder #(
		.WIDTH(WIDTH)
	) imm_adder (
		.a_in(state.working_register),
		.b_in(REQ_IN.imm_data),
		.result_out(add_imm)
	);

	// *****************************
	// Next state
	// *****************************
	logic [WIDTH-1:0] and_mem;
	logic [WIDTH-1:0] and_imm;

	always_comb begin
		and_mem = state.working_register & REQ_IN.mem_data;
		and_imm = state.working_register & REQ_IN.imm_data;
		next_state = state;
		next_state.mem_wr.write = 1'b0; // Write strobe lasts one cycle
		next_state.done = 1'b0;
		if (REQ_IN.valid) begin
			next_state.done = 1'b1;
			case (REQ_IN.op)
				OP_ADD_MEM: begin
					next_state.working_register = add_mem.sum;
					next_state.flags = add_mem.flags;
				end
				OP_ADD_IMM: begin
					next_state.working_register = add_imm.sum;
					next_state.flags = add_imm.flags;
				end
				OP_ADD_INTO_MEM: begin
					// Working register kept; only memory takes the sum
					next_state.mem_wr.write = 1'b1;
					next_state.mem_wr.data = add_mem.sum;
					next_state.flags = add_mem.flags;
				end
				OP_AND_MEM: begin
					next_state.working_register = and_mem;
					next_state.flags.zero = is_zero(and_mem);
				end
				OP_AND_IMM: begin
					next_state.working_register = and_imm;
					next_state.flags.zero = is_zero(and_imm);
				end
				OP_AND_INTO_MEM: begin
					// Destination assumed memory, mirroring add-into-memory
					next_state.mem_wr.write = 1'b1;
					next_state.mem_wr.data = and_mem;
					next_state.flags.zero = is_zero(and_mem);
				end
				default: begin
					next_state.done = 1'b0; // Unknown codes do nothing
				end
			endcase
		end
	end

	// *****************************
	// Registers
	// *****************************
	always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			state.working_register <= `WORK_RESET;
			state.flags <= alu_flags_t'(`FLAGS_RESET);
			state.mem_wr <= mem_write_t'(9'h000);
			state.done <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// Outputs straight from flip-flops
	assign WORKING_REGISTER_OUT = state.working_register;
	assign FLAGS_OUT = state.flags;
	assign MEM_WRITE_OUT = state.mem_wr;
	assign DONE_OUT = state.done;

endmodule

/* test/alu_dp_monitor.sv */
// Checker on the datapath top ports.
// Assumes the package is compiled first.
module alu_dp_monitor
	import alu_datapath_pkg::*;
(
	input wire logic CLOCK_IN, // Clock
	input wire logic RESET_N_IN, // Reset
	input alu_req_t REQ_IN, // Request
	input logic [7:0] WORKING_REGISTER_OUT, // Work
	input alu_flags_t FLAGS_OUT, // Flags
	input mem_write_t MEM_WRITE_OUT, // Write-back
	input logic DONE_OUT // Done
);
	wire logic [7:0] w = WORKING_REGISTER_OUT;
	wire logic [7:0] m = REQ_IN.mem_data;
	wire logic [7:0] x = REQ_IN.imm_data;
	// Sign-extended sum: its top bit is the true sign, a split top pair means wrap
	wire logic [8:0] sx = {w[7], w} + {m[7], m};
	wire logic [4:0] hx = {1'b0, w[3:0]} + {1'b0, m[3:0]};
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (!RESET_N_IN);
	// Request of one kind taken
	sequence s_op(alu_op_t o);
		REQ_IN.valid && REQ_IN.op == o;
	endsequence
	AST_ADD_WORKING_INTO_MEMORY: assert property (s_op(OP_ADD_INTO_MEM)
		|=> MEM_WRITE_OUT.write && MEM_WRITE_OUT.data == 8'($past(w) + $past(m)) && $stable(w))
		else $error("add into memory wrong");
	AST_ADD_WORKING_INTO_MEMORY_FL: assert property (s_op(OP_ADD_INTO_MEM)
		|=> FLAGS_OUT.carry == ({1'b0, $past(w)} + $past(m) > 9'h0ff)
		&& FLAGS_OUT.zero == (MEM_WRITE_OUT.data == 8'h00)) else $error("add flags wrong");
	AST_ANDMEM: assert property (s_op(OP_AND_MEM)
		|=> w == ($past(w) & $past(m))) else $error("and memory wrong");
	AST_ANDIMM: assert property (s_op(OP_AND_IMM)
		|=> w == ($past(w) & $past(x))) else $error("and immediate wrong");
	AST_ANDFL: assert property (REQ_IN.valid && REQ_IN.op inside {OP_AND_MEM, OP_AND_IMM}
		|=> $stable({FLAGS_OUT.carry, FLAGS_OUT.half, FLAGS_OUT.wrap, FLAGS_OUT.sign})
		&& FLAGS_OUT.zero == (w == 8'h00)) else $error("and flags wrong");
	AST_AND_WORKING_INTO_MEMORY: assert property (s_op(OP_AND_INTO_MEM)
		|=> MEM_WRITE_OUT.write && MEM_WRITE_OUT.data == ($past(w) & $past(m)))
		else $error("and into memory wrong");
	AST_ADDIMM: assert property (s_op(OP_ADD_IMM)
		|=> w == 8'($past(w) + $past(x)) && FLAGS_OUT.zero == (w == 8'h00))
		else $error("add immediate wrong");
	AST_ADDMEM_FL: assert property (s_op(OP_ADD_MEM)
		|=> FLAGS_OUT.half == $past(hx[4]) && FLAGS_OUT.sign == $past(sx[8])
		&& FLAGS_OUT.wrap == ($past(sx[8]) != $past(sx[7])))
		else $error("add memory flags wrong");
	AST_ADD_WORKING_INTO_MEMORY_SGN: assert property (s_op(OP_ADD_INTO_MEM)
		|=> FLAGS_OUT.half == $past(hx[4]) && FLAGS_OUT.sign == $past(sx[8])
		&& FLAGS_OUT.wrap == ($past(sx[8]) != $past(sx[7])))
		else $error("add into memory flags wrong");
	AST_IDLE: assert property (!REQ_IN.valid
		|=> !DONE_OUT && !MEM_WRITE_OUT.write && $stable(w))
		else $error("idle cycle changed state");
endmodule
bind add_and_logic_datapath alu_dp_monitor u_alu_dp_monitor (.CLOCK_IN(CLOCK_IN),
	.RESET_N_IN(RESET_N_IN), .REQ_IN(REQ_IN), .WORKING_REGISTER_OUT(WORKING_REGISTER_OUT),
	.FLAGS_OUT(FLAGS_OUT), .MEM_WRITE_OUT(MEM_WRITE_OUT), .DONE_OUT(DONE_OUT));

/* test/data_byte_mem.sv */
// Model of the addressed data memory byte.
// Assumes a one-clock write strobe.
module data_byte_mem
	import alu_datapath_pkg::*;
(
	input wire logic clk_in, // Clock
	input wire logic rst_n_in, // Reset
	input mem_write_t wr_in, // Write-back
	output logic [7:0] byte_out // Stored byte
);
	// Nonzero start so sums are not trivial
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			byte_out <= 8'h3c;
		else if (wr_in.write)
			byte_out <= wr_in.data;
	end
endmodule

/* test/tb_add_and_logic_datapath.sv */
// Bench for the datapath: random ops, queued expectations.
// Assumes the checker is bound by its own file.
module tb_add_and_logic_datapath;
	import alu_datapath_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, reset_n = 0, dn, zm = 0, cm = 0;
	alu_req_t req = '0;
	alu_op_t o;
	alu_flags_t fl;
	mem_write_t mw;
	logic [7:0] wr, mb, m, x, b, r, wm = 0;
	logic [8:0] s;
	logic [17:0] q[$], e;
	int seed = 76572, errors = 0, comparisons = 0;
	always #4 clock = ~clock;
	add_and_logic_datapath u_add_and_logic_datapath (.CLOCK_IN(clock), .RESET_N_IN(reset_n),
		.REQ_IN(req), .WORKING_REGISTER_OUT(wr), .FLAGS_OUT(fl), .MEM_WRITE_OUT(mw),
		.DONE_OUT(dn));
	data_byte_mem u_data_byte_mem (.clk_in(clock), .rst_n_in(reset_n), .wr_in(mw),
		.byte_out(mb));
	task chk(input string n, input logic [7:0] ev, input logic [7:0] sv);
		comparisons++;
		if (ev !== sv) begin
			errors++;
			$display("BAD %s exp %h got %h", n, ev, sv);
		end
	endtask
	task results;
		if (errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Results settle by the falling edge
	always @(negedge clock) if (dn === 1'b1) begin
		e = q.size() ? q.pop_front() : 18'h3ffff;
		chk("work", e[17:10], wr);
		if (mw.write === 1'b1) chk("mem", e[9:2], mw.data);
		chk("zero", 8'(e[1]), 8'(fl.zero));
		chk("carry", 8'(e[0]), 8'(fl.carry));
	end
	// First eight ops cover every code, refused ones too
	initial begin
		repeat (12) @(negedge clock);
		reset_n = 1;
		for (int i = 0; i < 90; i++) begin
			@(negedge clock);
			o = alu_op_t'(3'(i < 8 ? i : $random(seed)));
			m = $random(seed);
			x = $random(seed);
			if (o == OP_ADD_INTO_MEM || o == OP_AND_INTO_MEM) m = mb;
			req = '{1'b1, o, m, x};
			b = (o == OP_ADD_IMM || o == OP_AND_IMM) ? x : m;
			s = wm + b;
			r = o < OP_AND_MEM ? s[7:0] : wm & b;
			if (o inside {[1:6]}) begin
				if (o < OP_AND_MEM) cm = s[8];
				zm = r == 8'h00;
				if (o != OP_ADD_INTO_MEM && o != OP_AND_INTO_MEM) wm = r;
				q.push_back({wm, r, zm, cm});
			end
		end
		@(negedge clock);
		req = '0;
		repeat (3) @(negedge clock);
		chk("left", 8'h00, 8'(q.size()));
		results;
	end
endmodule
